// ### hw/smsc_regs.vh
// register offsets, field positions, reset values and timing counts for
// the master bus status and control block.
// assumes a 250 MHz core clock and byte addresses on the register port.
`ifndef SMSC_REGS_VH
`define SMSC_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SMSC_OFF_STATUS 12'h344
`define SMSC_OFF_CONTROL 12'h348
`define SMSC_OFF_IRQ_MASK 12'h3F0

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define SMSC_ST_INIT_DONE 24
`define SMSC_ST_NO_ACK 25
`define SMSC_ST_LOST_ARB 26
`define SMSC_ST_MISPLACED 27
`define SMSC_ST_CHECKSUM 28
`define SMSC_ST_UNMAPPED 29
`define SMSC_ST_ERR_LSB 25
`define SMSC_ST_ERR_MSB 29
`define SMSC_STATUS_RST 32'h00000000

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define SMSC_CT_PRESC_MSB 15
`define SMSC_CT_PRESC_LSB 0
`define SMSC_CT_IGN_MASTERS 16
`define SMSC_CT_IGN_CHECKSUM 17
`define SMSC_CT_TOUT_DIS 22
`define SMSC_PRESC_RST 16'h0139
`define SMSC_CONTROL_WMASK 32'h0043FFFF

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SMSC_CLK_NS 4
`define SMSC_BASE_NS 32
`define SMSC_BASE_CYC ((`SMSC_BASE_NS + `SMSC_CLK_NS - 1) / `SMSC_CLK_NS)
`define SMSC_ARB_TRIES 16
`define SMSC_TOUT_US 25000
`define SMSC_TOUT_CYC (`SMSC_TOUT_US * 1000 / `SMSC_CLK_NS)

`endif

// ### hw/smsc_top.v
// status and control logic of the master bus interface: prescaler clock,
// arbitration retry and abort, error flags, init status, interrupt.
// assumes a bus engine that reports events as one-cycle pulses on mclk.
//
// Summary of operation
// RL1 - each of the first fifteen losses in a row asks for a retry, and the sixteenth loss in a row aborts the transaction and sets the lost-arbitration flag.
// RL2 - an unexpected negative acknowledge during a master transaction sets the no-acknowledge flag.
// RL3 - a start or stop condition seen in an unexpected place sets the misplaced-condition flag.
// RL4 - a bad init checksum or a missing configuration-done command sets the init checksum flag.
// RL5 - an init load aimed at a register that does not exist sets the unmapped-init flag.
// RL6 - in eeprom-init mode the read-only init-done bit sets when init finishes or an init error is found.
// RL7 - the prescaler clock period is 32 ns times the 16-bit prescaler field.
// RL8 - a prescaler field of zero or one stops the prescaler clock.
// RL9 - the prescaler field comes out of reset holding 0x0139 for 100 kHz.
// RL10 - with ignore-other-masters set, a lost arbitration neither retries nor aborts and the transaction goes on.
// RL11 - with ignore-checksum set, checksum failures are never reported.
// RL12 - with timeout-disable set, no bus timeout is ever detected.
// RL13 - an error flag stays set until a one is written to its bit, and a zero leaves it alone.
//
// The address-and-strobe port was decided locally.
`include "smsc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module smsc_top #(
    parameter TOUT_CYCLES = `SMSC_TOUT_CYC,
    parameter TOUT_W = 23
) (
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // register port
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_r,
    // configuration strap
    input wire eeprom_init_mode,
    // events from the bus engine
    input wire txn_start,
    input wire arb_won,
    input wire arb_lost,
    input wire nack_seen,
    input wire misplaced_cond,
    input wire bus_clk_low,
    // events from the init sequencer
    input wire init_finished,
    input wire checksum_bad,
    input wire cfg_done_missing,
    input wire unmapped_init,
    // controls to the bus engine
    output reg presc_clk_r,
    output reg presc_tick_r,
    output reg arb_retry_r,
    output reg arb_abort_r,
    output reg ignore_masters_r,
    output reg bus_timeout_r,
    // interrupt
    output reg irq_r
);

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    reg [31:0] control_r;
    reg [4:0] err_r;
    reg [4:0] err_nxt;
    reg [4:0] mask_r;
    reg init_done_r;
    reg init_mode_r;
    reg strap_taken_r;
    reg [4:0] err_set;
    reg [4:0] err_clr;
    wire wr_status = reg_wr && (reg_addr == `SMSC_OFF_STATUS);
    wire wr_control = reg_wr && (reg_addr == `SMSC_OFF_CONTROL);
    wire wr_mask = reg_wr && (reg_addr == `SMSC_OFF_IRQ_MASK);
    wire [15:0] presc_w = control_r[`SMSC_CT_PRESC_MSB:`SMSC_CT_PRESC_LSB];
    wire ign_cs_w = control_r[`SMSC_CT_IGN_CHECKSUM];
    wire tout_dis_w = control_r[`SMSC_CT_TOUT_DIS];
    wire [31:0] status_w;
    reg lost_abort;

    assign status_w = {2'h0, err_r, init_done_r, 24'h000000};

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            // RL9 - boot prescaler value
            control_r <= {16'h0000, `SMSC_PRESC_RST};
            ignore_masters_r <= 1'b0;
        end else begin
            if (wr_control) begin
                control_r <= reg_wdata & `SMSC_CONTROL_WMASK;
            end
            ignore_masters_r <= wr_control ?
                reg_wdata[`SMSC_CT_IGN_MASTERS] :
                control_r[`SMSC_CT_IGN_MASTERS];
        end
    end

    // ------------------------------------------------------------------
    // error flags
    // ------------------------------------------------------------------
    always @* begin
        err_set = 5'h00;
        // RL2 - no acknowledge
        err_set[`SMSC_ST_NO_ACK - `SMSC_ST_ERR_LSB] = nack_seen;
        // RL1 - abort after losses
        err_set[`SMSC_ST_LOST_ARB - `SMSC_ST_ERR_LSB] = lost_abort;
        // RL3 - misplaced start or stop
        err_set[`SMSC_ST_MISPLACED - `SMSC_ST_ERR_LSB] = misplaced_cond;
        // RL4 - checksum or missing done
        // RL11 - checksum always passes
        err_set[`SMSC_ST_CHECKSUM - `SMSC_ST_ERR_LSB] =
            (checksum_bad && !ign_cs_w) || cfg_done_missing;
        // RL5 - unmapped init target
        err_set[`SMSC_ST_UNMAPPED - `SMSC_ST_ERR_LSB] = unmapped_init;
        err_clr = wr_status ?
            reg_wdata[`SMSC_ST_ERR_MSB:`SMSC_ST_ERR_LSB] : 5'h00;
        // RL13 - write one to clear, set wins
        err_nxt = (err_r & ~err_clr) | err_set;
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            err_r <= 5'h00;
            mask_r <= 5'h00;
            irq_r <= 1'b0;
        end else begin
            err_r <= err_nxt;
            if (wr_mask) begin
                mask_r <= reg_wdata[`SMSC_ST_ERR_MSB:`SMSC_ST_ERR_LSB];
            end
            // level interrupt follows the flags in the same cycle, from err_nxt
            irq_r <= |(err_nxt & (wr_mask ?
                reg_wdata[`SMSC_ST_ERR_MSB:`SMSC_ST_ERR_LSB] : mask_r));
        end
    end

    // ------------------------------------------------------------------
    // init status
    // ------------------------------------------------------------------
    // strap is caught on the first clock after reset release, not in reset
    always @(posedge mclk) begin
        if (sys_rst) begin
            strap_taken_r <= 1'b0;
            init_mode_r <= 1'b0;
            init_done_r <= 1'b0;
        end else begin
            if (!strap_taken_r) begin
                strap_taken_r <= 1'b1;
                init_mode_r <= eeprom_init_mode;
            end
            // RL6 - done on finish or error
            if (init_mode_r && (init_finished || cfg_done_missing ||
                    unmapped_init || (checksum_bad && !ign_cs_w))) begin
                init_done_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata_r <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SMSC_OFF_STATUS: reg_rdata_r <= status_w;
                `SMSC_OFF_CONTROL: reg_rdata_r <= control_r;
                `SMSC_OFF_IRQ_MASK: reg_rdata_r <= {2'h0, mask_r, 25'h0};
                default: reg_rdata_r <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_r <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------------
    // prescaler clock
    // ------------------------------------------------------------------
    // base tick every 32 ns; period counts whole base ticks, so the
    // prescaler output is coarse but glitch free
    localparam BASE_CYC = `SMSC_BASE_CYC;
    reg [3:0] base_cnt_r;
    reg [15:0] presc_cnt_r;
    wire presc_run = (presc_w > 16'h0001);
    wire base_tick = (base_cnt_r == BASE_CYC[3:0] - 4'h1);

    always @(posedge mclk) begin
        if (sys_rst) begin
            base_cnt_r <= 4'h0;
            presc_cnt_r <= 16'h0000;
            presc_clk_r <= 1'b0;
            presc_tick_r <= 1'b0;
        end else if (!presc_run) begin
            // RL8 - stopped at zero or one
            base_cnt_r <= 4'h0;
            presc_cnt_r <= 16'h0000;
            presc_clk_r <= 1'b0;
            presc_tick_r <= 1'b0;
        end else begin
            base_cnt_r <= base_tick ? 4'h0 : base_cnt_r + 4'h1;
            presc_tick_r <= 1'b0;
            if (base_tick) begin
                // RL7 - period of N base ticks
                if (presc_cnt_r >= presc_w - 16'h0001) begin
                    presc_cnt_r <= 16'h0000;
                    presc_tick_r <= 1'b1;
                    presc_clk_r <= 1'b1;
                end else begin
                    presc_cnt_r <= presc_cnt_r + 16'h0001;
                    if (presc_cnt_r + 16'h0001 >= {1'b0, presc_w[15:1]}) begin
                        presc_clk_r <= 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // arbitration retry
    // ------------------------------------------------------------------
    localparam ARB_LAST = `SMSC_ARB_TRIES - 1;
    reg [4:0] loss_cnt_r;
    wire ign_om_w = control_r[`SMSC_CT_IGN_MASTERS];

    always @* begin
        lost_abort = arb_lost && !ign_om_w &&
            (loss_cnt_r == ARB_LAST[4:0]);
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            loss_cnt_r <= 5'h00;
            arb_retry_r <= 1'b0;
            arb_abort_r <= 1'b0;
        end else begin
            arb_retry_r <= 1'b0;
            arb_abort_r <= 1'b0;
            if (txn_start || arb_won) begin
                loss_cnt_r <= 5'h00;
            end else if (arb_lost && ign_om_w) begin
                // RL10 - other masters ignored
                loss_cnt_r <= 5'h00;
            end else if (arb_lost) begin
                // RL1 - retry then abort
                if (lost_abort) begin
                    loss_cnt_r <= 5'h00;
                    arb_abort_r <= 1'b1;
                end else begin
                    loss_cnt_r <= loss_cnt_r + 5'h01;
                    arb_retry_r <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // bus timeout
    // ------------------------------------------------------------------
    reg [TOUT_W-1:0] tout_cnt_r;

    always @(posedge mclk) begin
        if (sys_rst) begin
            tout_cnt_r <= {TOUT_W{1'b0}};
            bus_timeout_r <= 1'b0;
        end else if (tout_dis_w || !bus_clk_low) begin
            // RL12 - timeouts disabled, or bus clock not held low
            tout_cnt_r <= {TOUT_W{1'b0}};
            bus_timeout_r <= 1'b0;
        end else begin
            bus_timeout_r <= 1'b0;
            if (tout_cnt_r == TOUT_CYCLES[TOUT_W-1:0] - 1'b1) begin
                tout_cnt_r <= {TOUT_W{1'b0}};
                bus_timeout_r <= 1'b1;
            end else begin
                tout_cnt_r <= tout_cnt_r + 1'b1;
            end
        end
    end

endmodule // smsc_top

`default_nettype wire

// ### verification/smsc_assertions.sv
// checker for the master bus status block, watching top-level ports only
// assumes shadow copies of control and mask track the register writes
`timescale 1ns/1ps
`default_nettype none
module smsc_assertions #(
    parameter TOUT_CYCLES = 20
) (
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // register port
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    // events
    input wire arb_lost,
    input wire nack_seen,
    input wire checksum_bad,
    input wire bus_clk_low,
    // outputs
    input wire presc_clk_r,
    input wire presc_tick_r,
    input wire arb_retry_r,
    input wire arb_abort_r,
    input wire bus_timeout_r,
    input wire irq_r
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    reg [31:0] ctl_r;
    reg [4:0] msk_r;
    reg [15:0] low_r;
    // shadows avoid peeking into the body; they lag a write by no cycle
    always @(posedge mclk) begin
        if (sys_rst) begin
            ctl_r <= 32'h00000139;
            msk_r <= 5'h00;
            low_r <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == 12'h348)
                ctl_r <= reg_wdata;
            if (reg_wr && reg_addr == 12'h3F0)
                msk_r <= reg_wdata[29:25];
            low_r <= bus_clk_low ? low_r + 16'h0001 : 16'h0000;
        end
    end
    property p_nack; nack_seen && msk_r[0] |=> irq_r; endproperty
    a_nack: assert property (p_nack) else $error("nack irq missing");
    property p_chk; checksum_bad && !ctl_r[17] && msk_r[3] |=> irq_r;
    endproperty
    a_chk: assert property (p_chk) else $error("checksum irq missing");
    property p_retry; arb_lost && !ctl_r[16] |=> arb_retry_r || arb_abort_r;
    endproperty
    a_retry: assert property (p_retry) else $error("no retry");
    property p_ign; ctl_r[16] && $past(ctl_r[16]) |->
        !arb_retry_r && !arb_abort_r; endproperty
    a_ign: assert property (p_ign) else $error("retry while ignoring");
    property p_stop; ctl_r[15:0] <= 16'h0001 && $past(ctl_r) <= 32'h1 |->
        !presc_tick_r && !presc_clk_r; endproperty
    a_stop: assert property (p_stop) else $error("clock not stopped");
    property p_period; presc_tick_r && ctl_r[15:0] == 16'h0002 &&
        $past(ctl_r, 24) == 32'h2 |-> $past(presc_tick_r, 16) &&
        !$past(presc_tick_r, 8); endproperty
    a_period: assert property (p_period) else $error("bad period");
    property p_tout; bus_timeout_r |-> low_r >= TOUT_CYCLES - 1; endproperty
    a_tout: assert property (p_tout) else $error("early timeout");
    property p_tdis; ctl_r[22] && $past(ctl_r[22]) |-> !bus_timeout_r;
    endproperty
    a_tdis: assert property (p_tdis) else $error("timeout disabled");
    c_abort: cover property (arb_abort_r);
    c_tout: cover property (bus_timeout_r);
    c_tick: cover property (presc_tick_r && ctl_r[15:0] == 16'h0002);
endmodule // smsc_assertions
bind smsc_top smsc_assertions #(.TOUT_CYCLES(TOUT_CYCLES)) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .arb_lost(arb_lost),
    .nack_seen(nack_seen), .checksum_bad(checksum_bad),
    .bus_clk_low(bus_clk_low), .presc_clk_r(presc_clk_r),
    .presc_tick_r(presc_tick_r), .arb_retry_r(arb_retry_r),
    .arb_abort_r(arb_abort_r), .bus_timeout_r(bus_timeout_r),
    .irq_r(irq_r));
`default_nettype wire

// ### verification/smsc_far.sv
// far-side model: bus engine and init sequencer as event sources
// assumes callers enter just after a rising edge of mclk
`timescale 1ns/1ps
`default_nettype none
module smsc_far (
    // clock
    input wire mclk,
    // one bit per event source; bit 9 is the clock-low level
    output var logic [9:0] ev
);
    initial ev = 10'h000;
    // quiet cycle after each pulse so two pulses never merge
    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge mclk);
        ev[k] <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic hold_low(input int n);
        ev[9] <= 1'b1;
        repeat (n) @(posedge mclk);
        ev[9] <= 1'b0;
        @(posedge mclk);
    endtask
endmodule // smsc_far
`default_nettype wire

// ### verification/test_smbus_master_status_control.sv
// self-checking bench for the master bus status block
// assumes the design, its checker and the far-side model are compiled
`timescale 1ns/1ps
`default_nettype none
module test_smbus_master_status_control;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic strap = 1'b1;
    wire [9:0] ev;
    wire [31:0] rdata;
    wire tick, pclk, retry, abort, ignm, tout, irq;
    logic [15:0] n_retry = 16'h0, n_abort = 16'h0, n_tout = 16'h0;
    logic [31:0] st;
    longint t0;
    int error_cnt = 0;
    int comparisons = 0;
    always #2 mclk = ~mclk;
    // counted mid-cycle so a check right after an edge sees the pulse
    always @(negedge mclk) begin
        n_retry <= n_retry + 16'(retry);
        n_abort <= n_abort + 16'(abort);
        n_tout <= n_tout + 16'(tout);
    end
    smsc_far u_far (.mclk(mclk), .ev(ev));
    smsc_top #(.TOUT_CYCLES(20)) u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(rdata), .eeprom_init_mode(strap),
        .txn_start(ev[0]), .arb_won(ev[1]), .arb_lost(ev[2]),
        .nack_seen(ev[3]), .misplaced_cond(ev[4]), .bus_clk_low(ev[9]),
        .init_finished(ev[5]), .checksum_bad(ev[6]),
        .cfg_done_missing(ev[7]), .unmapped_init(ev[8]),
        .presc_clk_r(pclk), .presc_tick_r(tick), .arb_retry_r(retry),
        .arb_abort_r(abort), .ignore_masters_r(ignm),
        .bus_timeout_r(tout), .irq_r(irq));
    task chk(input string n, input [31:0] e, input [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task rc(input [11:0] a, input [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        chk("regread", e, rdata);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // bounded wait; running out ends the run as a mismatch
    task wait_tick;
        int i;
        for (i = 0; tick !== 1'b1; i++) begin
            @(posedge mclk);
            if (i > 400) begin
                error_cnt++;
                give_verdict;
            end
        end
    endtask
    task t_flags;
        int k;
        int src[4] = '{3, 4, 7, 8};
        int pos[4] = '{25, 27, 28, 29};
        rc(12'h348, 32'h00000139);
        rc(12'h344, 32'h00000000);
        rc(12'h340, 32'h00000000);
        wr(12'h3F0, 32'h3E000000);
        u_far.pulse(5);
        st = 32'h01000000;
        rc(12'h344, st);
        for (k = 0; k < 4; k++) begin
            u_far.pulse(src[k]);
            st[pos[k]] = 1'b1;
            rc(12'h344, st);
        end
        chk("irq", 1, 32'(irq));
        wr(12'h344, 32'h00000000);
        rc(12'h344, st);
        wr(12'h344, 32'h03000000);
        st[25] = 1'b0;
        rc(12'h344, st);
        wr(12'h344, 32'h3E000000);
        wr(12'h3F0, 32'h00000000);
        u_far.pulse(3);
        chk("irq", 0, 32'(irq));
        rc(12'h344, 32'h03000000);
        wr(12'h344, 32'h02000000);
        wr(12'h3F0, 32'h3E000000);
        $display("flags done");
    endtask
    task t_chk;
        wr(12'h348, 32'h00020139);
        u_far.pulse(6);
        rc(12'h344, 32'h01000000);
        wr(12'h348, 32'h00000139);
        u_far.pulse(6);
        rc(12'h344, 32'h11000000);
        wr(12'h344, 32'h10000000);
        $display("checksum done");
    endtask
    task t_arb;
        repeat (15) u_far.pulse(2);
        chk("retries", 15, 32'(n_retry));
        u_far.pulse(2);
        @(posedge mclk);
        chk("aborts", 1, 32'(n_abort));
        rc(12'h344, 32'h05000000);
        wr(12'h344, 32'h04000000);
        u_far.pulse(1);
        repeat (15) u_far.pulse(2);
        chk("retries", 30, 32'(n_retry));
        wr(12'h348, 32'h00010139);
        repeat (16) u_far.pulse(2);
        chk("ignore", 1, 32'(ignm));
        chk("retries", 31, 32'(n_retry) + 32'(n_abort));
        wr(12'h348, 32'h00000139);
        $display("arbitration done");
    endtask
    task t_clk;
        wr(12'h348, 32'h00000002);
        wait_tick;
        t0 = $time;
        @(posedge mclk);
        wait_tick;
        chk("period_ns", 64, 32'($time - t0));
        wr(12'h348, 32'h00000001);
        repeat (40) @(posedge mclk);
        chk("stopped", 0, {30'h0, pclk, tick});
        wr(12'h348, 32'h00000139);
        u_far.hold_low(25);
        chk("timeouts", 1, 32'(n_tout));
        wr(12'h348, 32'h00400139);
        u_far.hold_low(45);
        chk("timeouts", 1, 32'(n_tout));
        $display("clock and timeout done");
    endtask
    // second reset with the strap low: init-done must never set
    task t_strap;
        sys_rst <= 1'b1;
        strap <= 1'b0;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        u_far.pulse(5);
        rc(12'h344, 32'h00000000);
        rc(12'h348, 32'h00000139);
        $display("strap done");
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_flags;
        t_chk;
        t_arb;
        t_clk;
        t_strap;
        give_verdict;
    end
endmodule // test_smbus_master_status_control
`default_nettype wire
